// >>> rtl/aas_aux_adc_ctrl.sv
// What this block does
// (R1) Input select 00/01/10/11 routes external a, external b, half supply, half io supply.
// (R2) One conversion takes 12 conversion clock edges: sample, ten bits, load.
// (R3) Every averaged conversion also takes 12 conversion clock edges.
// (R4) Conversion clock is system clock divided by 2 to the divider code.
// (R5) Host picks a divider keeping the conversion clock below 4 MHz.
// (R6) Total time is 12 times average count times divisor system clocks.
// (R7) Average code picks 1, 2, 4, 8, 16 or 32 conversions; upper codes 32.
// (R8) Serial data output floats when no status or readout is active.
// (R9) Writing the start bit drives serial output high as busy.
// (R10) After the last conversion store result and drive serial output low.
// (R11) With readout enabled, result appears from the next chip select fall.
// (R12) Result shifts out MSB first, changing on serial clock falling edges.
// (R13) After a readout, serial output floats as soon as chip select rises.
// (R14) With readout disabled the result never appears on the serial output.
// (R15) Instructions are accepted whatever the serial output is doing.
// (R16) Host holds serial input high while reading the result.
// (R17) Instructions to address 1111 are discarded, changing nothing.
// (R18) Reset gives external input a, divisor 1 and a single conversion.
// (R19) Start bit clears at the end; writes to it during conversion do nothing.
// (R20) Three adjacent mode bits form the averaging count field.
// (R21) Words shift in MSB first on rising serial clock, apply at chip select rise.
// (R22) Averaged result is the mean of conversions truncated to 10 bits.
`timescale 1ns/1ps
module aas_aux_adc_ctrl
  import aas_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial port pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout_out,
  output logic dout_oe,
  // Converter core
  output logic [1:0] adc_input_sel,
  output logic adc_sample,
  output logic adc_bit_strobe,
  input wire logic [AAS_RESULT_BITS-1:0] adc_code,
  // Status
  output logic start_convert_bit,
  output aas_cfg_t cfg,
  output logic [AAS_RESULT_BITS-1:0] result
);

  typedef struct packed {
    aas_cfg_t cfg;
    aas_state_t state;
    logic [2:0] run_div;
    logic [2:0] run_shift;
    logic [3:0] edge_idx;
    logic [5:0] conv_cnt;
    logic [AAS_ACC_BITS-1:0] acc;
    logic [AAS_RESULT_BITS-1:0] result;
    logic [AAS_WORD_BITS-1:0] rx;
    logic [4:0] rx_cnt;
    logic [AAS_RESULT_BITS-1:0] tx;
    logic cs_q;
    logic sclk_q;
    logic dout;
    logic dout_oe;
    logic sample;
    logic bit_strobe;
  } aas_st_t;

  aas_st_t st_r;
  aas_st_t st_nxt;

  logic [2:0] lvl;
  logic cs_l;
  logic sclk_l;
  logic din_l;
  logic tick;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic word_ok;
  logic [AAS_ACC_BITS-1:0] sum;
  logic [5:0] last_conv;

  // ----------------------------------------
  // Pin synchroniser and conversion clock divider
  // ----------------------------------------
  aas_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin_in({cs_n, sclk, din}),
    .level_out(lvl)
  );

  assign cs_l = lvl[2];
  assign sclk_l = lvl[1];
  assign din_l = lvl[0];

  aas_divider u_div (
    .clock(clock),
    .rst(rst),
    .run(st_r.state == ST_BUSY),
    .div_code(st_r.run_div),
    .tick(tick)
  );

  assign cs_fall = st_r.cs_q && !cs_l;
  assign cs_rise = !st_r.cs_q && cs_l;
  assign sclk_rise = !cs_l && !st_r.sclk_q && sclk_l;
  assign sclk_fall = !cs_l && st_r.sclk_q && !sclk_l;
  assign word_ok = (st_r.rx_cnt == 5'(AAS_WORD_BITS));
  assign sum = st_r.acc + AAS_ACC_BITS'(adc_code);
  assign last_conv = 6'((7'h01 << st_r.run_shift) - 7'h01);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_q = cs_l;
    st_nxt.sclk_q = sclk_l;
    st_nxt.sample = 1'b0;
    st_nxt.bit_strobe = 1'b0;

    // Serial receive.
    if (cs_fall) begin
      st_nxt.rx_cnt = '0;
    end
    // (R21) shift MSB first
    // (R15) independent of output
    if (sclk_rise) begin
      st_nxt.rx = {st_r.rx[AAS_WORD_BITS-2:0], din_l};
      if (st_r.rx_cnt != 5'(AAS_WORD_BITS)) begin
        st_nxt.rx_cnt = st_r.rx_cnt + 1'b1;
      end
    end

    // Conversion sequencer.
    if (st_r.state == ST_BUSY && tick) begin
      // (R2) twelve edges each
      // (R3) per averaged conversion
      if (st_r.edge_idx == AAS_EDGE_SAMPLE) begin
        st_nxt.sample = 1'b1;
        st_nxt.edge_idx = st_r.edge_idx + 1'b1;
      end else if (st_r.edge_idx != AAS_EDGE_LOAD) begin
        st_nxt.bit_strobe = 1'b1;
        st_nxt.edge_idx = st_r.edge_idx + 1'b1;
      end else begin
        st_nxt.edge_idx = AAS_EDGE_SAMPLE;
        st_nxt.acc = sum;
        st_nxt.conv_cnt = st_r.conv_cnt + 1'b1;
        // (R6) count times divisor
        if (st_r.conv_cnt == last_conv) begin
          // (R22) truncated mean
          st_nxt.result = AAS_RESULT_BITS'(sum >> st_r.run_shift);
          // (R10) ready drives low
          st_nxt.state = ST_READY;
          st_nxt.dout = 1'b0;
        end
      end
    end

    // Readout shifting.
    case (st_r.state)
      ST_READY: begin
        // (R11) present on cs fall
        // (R14) only when enabled
        if (cs_fall && st_r.cfg.readout_en) begin
          st_nxt.state = ST_SHIFT;
          st_nxt.tx = {st_r.result[AAS_RESULT_BITS-2:0], 1'b0};
          st_nxt.dout = st_r.result[AAS_RESULT_BITS-1];
        end
      end
      ST_SHIFT: begin
        // (R12) MSB first, falling edge
        if (sclk_fall) begin
          st_nxt.dout = st_r.tx[AAS_RESULT_BITS-1];
          st_nxt.tx = {st_r.tx[AAS_RESULT_BITS-2:0], 1'b0};
        end
        // (R13) float on cs rise
        if (cs_rise) begin
          st_nxt.state = ST_IDLE;
        end
      end
      ST_IDLE, ST_BUSY: begin
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase

    // Instruction apply at chip select rise.
    // (R17) ignore address 1111
    if (cs_rise && word_ok && st_r.rx[AAS_ADDR_MSB:AAS_ADDR_LSB] == AAS_MODE_ADDR &&
        AAS_MODE_ADDR != AAS_NULL_ADDR) begin
      // (R20) averaging field
      st_nxt.cfg.avg_code = st_r.rx[AAS_AVG_POS+:3];
      st_nxt.cfg.in_sel = st_r.rx[AAS_SEL_POS+:2];
      st_nxt.cfg.div_code = st_r.rx[AAS_DIV_POS+:3];
      st_nxt.cfg.readout_en = st_r.rx[AAS_RDEN_POS];
      // (R19) start ignored while busy
      // (R9) busy drives high
      if (st_r.rx[AAS_START_POS] && st_r.state != ST_BUSY) begin
        st_nxt.state = ST_BUSY;
        st_nxt.dout = 1'b1;
        st_nxt.edge_idx = AAS_EDGE_SAMPLE;
        st_nxt.conv_cnt = '0;
        st_nxt.acc = '0;
        st_nxt.run_div = st_r.rx[AAS_DIV_POS+:3];
        // (R7) average count select
        st_nxt.run_shift = aas_avg_shift(st_r.rx[AAS_AVG_POS+:3]);
      end
    end

    // (R8) floating when inactive
    st_nxt.dout_oe = (st_nxt.state != ST_IDLE);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      // (R18) reset defaults
      st_r.cfg <= '{readout_en: AAS_RDEN_RST, div_code: AAS_DIV_RST,
                    avg_code: AAS_AVG_RST, in_sel: AAS_SEL_RST};
      st_r.state <= ST_IDLE;
      st_r.cs_q <= 1'b1;
      st_r.sclk_q <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // (R1) mux code to core
  assign adc_input_sel = st_r.cfg.in_sel;
  assign adc_sample = st_r.sample;
  assign adc_bit_strobe = st_r.bit_strobe;
  assign dout_out = st_r.dout;
  assign dout_oe = st_r.dout_oe;
  // (R19) clears on finish
  assign start_convert_bit = (st_r.state == ST_BUSY);
  assign cfg = st_r.cfg;
  assign result = st_r.result;

endmodule : aas_aux_adc_ctrl

// >>> rtl/aas_divider.sv
`timescale 1ns/1ps
module aas_divider
  import aas_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [2:0] div_code,
  // Conversion clock edge
  output logic tick
);

  typedef struct packed {
    logic [AAS_DIV_CNT_BITS-1:0] cnt;
    logic tick;
  } aas_div_st_t;

  aas_div_st_t st_r;
  aas_div_st_t st_nxt;
  logic [AAS_DIV_CNT_BITS-1:0] limit;

  // ----------------------------------------
  // Power-of-two divider, one pulse per conversion clock edge
  // ----------------------------------------
  always_comb begin
    // (R4) power of two
    limit = AAS_DIV_CNT_BITS'((8'h01 << div_code) - 8'h01);
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == limit) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : aas_divider

// >>> rtl/aas_pkg.sv
package aas_pkg;

  // ----------------------------------------
  // Serial instruction layout
  // ----------------------------------------
  localparam int AAS_WORD_BITS = 16;
  localparam int AAS_ADDR_MSB = 15;
  localparam int AAS_ADDR_LSB = 12;
  localparam logic [3:0] AAS_MODE_ADDR = 4'ha;
  localparam logic [3:0] AAS_NULL_ADDR = 4'hf;

  // ----------------------------------------
  // Mode register field positions
  // ----------------------------------------
  localparam int AAS_START_POS = 0;
  localparam int AAS_SEL_POS = 2;
  localparam int AAS_AVG_POS = 4;
  localparam int AAS_DIV_POS = 7;
  localparam int AAS_RDEN_POS = 10;

  // ----------------------------------------
  // Input select codes and reset values
  // ----------------------------------------
  localparam logic [1:0] AAS_SEL_EXT_A = 2'h0;
  localparam logic [1:0] AAS_SEL_EXT_B = 2'h1;
  localparam logic [1:0] AAS_SEL_HALF_VDD = 2'h2;
  localparam logic [1:0] AAS_SEL_HALF_IO = 2'h3;
  localparam logic [1:0] AAS_SEL_RST = AAS_SEL_EXT_A;
  localparam logic [2:0] AAS_AVG_RST = 3'h0;
  localparam logic [2:0] AAS_DIV_RST = 3'h0;
  localparam logic AAS_RDEN_RST = 1'b0;

  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  localparam int AAS_RESULT_BITS = 10;
  localparam int AAS_EDGES_PER_CONV = 12;
  localparam logic [3:0] AAS_EDGE_SAMPLE = 4'h0;
  localparam logic [3:0] AAS_EDGE_LOAD = 4'hb;
  localparam int AAS_ACC_BITS = 15;
  localparam int AAS_DIV_CNT_BITS = 7;

  typedef struct packed {
    logic readout_en;
    logic [2:0] div_code;
    logic [2:0] avg_code;
    logic [1:0] in_sel;
  } aas_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_READY,
    ST_SHIFT
  } aas_state_t;

  // Averaging code to log2 of the conversion count; the upper codes saturate at 32.
  function automatic logic [2:0] aas_avg_shift(input logic [2:0] code);
    aas_avg_shift = (code > 3'h5) ? 3'h5 : code;
  endfunction : aas_avg_shift

endpackage : aas_pkg

// >>> rtl/aas_sync.sv
`timescale 1ns/1ps
module aas_sync
  import aas_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Asynchronous pins and their filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } aas_sync_st_t;

  aas_sync_st_t st_r;
  aas_sync_st_t st_nxt;

  // ----------------------------------------
  // Three-stage chain; a change counts once stages two and three agree.
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{s1: '1, s2: '1, s3: '1, lvl: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.lvl;

endmodule : aas_sync

// >>> verification/aas_chk_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module aas_chk
  import aas_pkg::*;
(
  // Clock, reset and serial pins
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_out,
  input wire logic dout_oe,
  // Core side and status
  input wire logic [1:0] adc_input_sel,
  input wire logic adc_sample,
  input wire logic adc_bit_strobe,
  input wire logic [AAS_RESULT_BITS-1:0] adc_code,
  input wire logic start_convert_bit,
  input wire aas_cfg_t cfg,
  input wire logic [AAS_RESULT_BITS-1:0] result
);
  logic [3:0] n_bits_r;
  logic [15:0] n_busy_r;
  logic [2:0] sh;
  int exp_c;
  assign sh = (cfg.avg_code > 3'h5) ? 3'h5 : cfg.avg_code;
  assign exp_c = (12 << (int'(sh) + int'(cfg.div_code))) + 1;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      n_bits_r <= 4'h0;
      n_busy_r <= 16'h0;
    end else begin
      n_bits_r <= adc_sample ? 4'h0 : n_bits_r + 4'(adc_bit_strobe);
      n_busy_r <= start_convert_bit ? n_busy_r + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_quiet;
    (!adc_bit_strobe && !adc_sample) [*8];
  endsequence
  a_sel_route: assert property (adc_sample |-> adc_input_sel == cfg.in_sel)
    else $error("input select differs from configuration");
  a_busy_rise: assert property ($rose(start_convert_bit) |-> dout_oe && dout_out)
    else $error("busy not shown at start");
  a_oe_cause: assert property ($rose(dout_oe) |-> start_convert_bit)
    else $error("output driven without a conversion");
  a_done_low: assert property ($fell(start_convert_bit) |-> dout_oe && !dout_out)
    else $error("ready not shown at done");
  a_float_cs: assert property ($fell(dout_oe) |-> cs_n)
    else $error("output released while selected");
  a_tick_space: assert property (adc_sample && cfg.div_code >= 3'h4 |=> s_quiet)
    else $error("conversion edges too close");
  a_ten_bits: assert property (adc_sample |-> n_bits_r == 4'h0 || n_bits_r == 4'ha)
    else $error("bit strobe count wrong");
  a_conv_time: assert property ($fell(start_convert_bit) |-> n_busy_r == 16'(exp_c))
    else $error("conversion time wrong");
endmodule : aas_chk

bind aas_aux_adc_ctrl aas_chk i_chk (.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk),
  .din(din), .dout_out(dout_out), .dout_oe(dout_oe), .adc_input_sel(adc_input_sel),
  .adc_sample(adc_sample), .adc_bit_strobe(adc_bit_strobe), .adc_code(adc_code),
  .start_convert_bit(start_convert_bit), .cfg(cfg), .result(result));

// >>> verification/aas_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial port host
// ----------------------------------------
module aas_host (
  // Clock and returned data
  input wire logic clock,
  input wire logic dout_w,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic din
);
  int ph = 6;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b1;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
    @(posedge clock);
    cs_n <= 1'b0;
    for (int b = 15; b >= 0; b--) begin
      din <= w[b];
      repeat (ph) @(posedge clock);
      sclk <= 1'b1;
      repeat (ph - 1) @(posedge clock);
      @(negedge clock);
      rd[b] = dout_w;
      @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (ph) @(posedge clock);
    din <= 1'b1;
    cs_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : xfer
endmodule : aas_host

// >>> verification/tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module tb
  import aas_pkg::*;
;
  logic clock = 1'b0;
  logic rst;
  logic cs_n, sclk, din, dout_out, dout_oe, adc_sample, adc_bit_strobe, start_convert_bit;
  logic [1:0] adc_input_sel;
  logic [9:0] adc_code, result, code, last_exp;
  aas_cfg_t cfg;
  logic dout_x = 1'b0;
  logic busy_q = 1'b0;
  logic [15:0] rd;
  logic [9:0] q[$];
  int n_fail = 0, check_count = 0, cyc = 0, need = 0, cnt = 0, acc = 0, sh_exp = 0, seed;
  wire dout_w = dout_oe ? dout_out : dout_x;

  aas_aux_adc_ctrl i_aas_aux_adc_ctrl (.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout_out(dout_out), .dout_oe(dout_oe), .adc_input_sel(adc_input_sel),
    .adc_sample(adc_sample), .adc_bit_strobe(adc_bit_strobe), .adc_code(adc_code),
    .start_convert_bit(start_convert_bit), .cfg(cfg), .result(result));
  aas_host i_aas_host (.clock(clock), .dout_w(dout_w), .cs_n(cs_n), .sclk(sclk), .din(din));

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  function automatic logic [15:0] wd(input logic [1:0] s, input logic [2:0] a, d,
                                     input logic r, st);
    wd = {AAS_MODE_ADDR, 1'b0, r, d, a, s, 1'b0, st};
  endfunction : wd

  // Core model: a fresh code per sample, the expected mean noted after the last one.
  always @(posedge clock) begin
    if (cyc == 0) seed = $urandom(32'hfcebec0f);
    dout_x <= ~dout_x;
    cyc <= cyc + 1;
    if (cyc > 90000) begin
      n_fail++;
      test_done;
    end
    if (adc_sample === 1'b1) begin
      code = 10'($urandom);
      adc_code <= code;
      acc += code;
      cnt++;
      if (cnt == need) begin
        last_exp = 10'(acc >> sh_exp);
        q.push_back(last_exp);
      end
    end
  end

  always @(negedge clock) begin
    if (busy_q === 1'b1 && start_convert_bit === 1'b0) begin
      check(16'(result), 16'(q.pop_front()), "result");
      check({15'h0, dout_oe & ~dout_out}, 16'h1, "ready");
    end
    busy_q = start_convert_bit;
  end

  task automatic run(input logic [1:0] s, input logic [2:0] a, d, input logic r);
    sh_exp = (a > 3'h5) ? 5 : int'(a);
    need = 1 << sh_exp;
    acc = 0;
    cnt = 0;
    i_aas_host.xfer(wd(s, a, d, r, 1'b1), rd);
    check(16'(cfg), 16'({r, d, a, s}), "cfg");
    check(16'(adc_input_sel), 16'(s), "input select");
    if (a == 3'h7) i_aas_host.xfer(wd(s, a, d, r, 1'b1), rd);
    for (int k = 0; k < 60000 && start_convert_bit !== 1'b0; k++) @(posedge clock);
    @(posedge clock);
    i_aas_host.xfer(16'hffff, rd);
    check(rd, r ? {last_exp, 6'h0} : 16'h0, "readout");
    check(16'(cfg), 16'({r, d, a, s}), "cfg kept");
    check(16'(dout_oe), 16'(!r), "float after cs");
  endtask : run

  initial begin
    rst = 1'b1;
    adc_code = 10'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    check(16'(cfg), 16'h0, "cfg reset");
    check(16'(dout_oe), 16'h0, "idle float");
    // Dividers stay at 16 or more so the conversion clock stays under 4 MHz.
    for (int i = 0; i < 8; i++) begin
      i_aas_host.ph = 4 + 2 * (i % 3);
      run(2'(i), 3'(i), (i < 4) ? 3'(7 - i) : 3'h4, i[0]);
    end
    test_done;
  end
endmodule : tb
